/* File: src/regfile_pkg.sv */
/*
 * Constants, address map and operation codes of the CPU register file and
 * stack pointer block.
 * Assumes a 16-bit data space address and an 8-bit data bus.
 */
`default_nettype none
package regfile_pkg;
    localparam int GPR_COUNT = 32;
    localparam logic [15:0] GPR_FIRST_ADDR = 16'h0000;
    localparam logic [15:0] GPR_LAST_ADDR = 16'h001F;
    localparam logic [4:0] X_LOW_INDEX = 5'h1A;
    localparam logic [4:0] Y_LOW_INDEX = 5'h1C;
    localparam logic [4:0] Z_LOW_INDEX = 5'h1E;
    localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
    localparam logic [5:0] IO_LAST_ADDR = 6'h3F;
    localparam logic [15:0] EXT_IO_BASE = 16'h0060;
    localparam logic [15:0] EXTZ_ADDR = 16'h005B;
    localparam logic [15:0] SP_LOW_ADDR = 16'h005D;
    localparam logic [15:0] SP_HIGH_OFFSET = 16'h0001;
    localparam logic [15:0] TEMP_ADDR = 16'h0060;
    localparam logic [15:0] SP_RESET = 16'h10FF;
    localparam logic [15:0] SP_IMPL_MASK = 16'h3FFF;
    localparam logic [7:0] EXTZ_RESET = 8'h00;
    localparam logic [7:0] EXTZ_IMPL_MASK = 8'hFF;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] STEP_INC1 = 8'h01;
    localparam logic [7:0] STEP_DEC1 = 8'hFF;
    localparam logic [7:0] STEP_INC2 = 8'h02;
    localparam logic [7:0] STEP_DEC2 = 8'hFE;

    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_type;
    typedef enum logic [1:0] {PTR_NONE, PTR_DISP, PTR_POSTINC, PTR_PREDEC} ptr_mode_type;
    typedef enum logic [2:0] {STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET} stack_op_type;
    typedef enum logic [1:0] {PROG_NONE, PROG_LOAD, PROG_EXT_LOAD, PROG_STORE} prog_op_type;
endpackage
`default_nettype wire

/* File: src/sixteen_step.sv */
/*
 * 16-bit adder that moves a pointer value by a signed 8-bit step.
 * Assumes the caller selects the step; purely combinational.
 */
`default_nettype none
module sixteen_step (
    input wire logic [15:0] value,
    input wire logic [7:0] step,
    output logic [15:0] result
);
    // carry runs across both bytes in one addition
    assign result = value + {{8{step[7]}}, step};
endmodule
`default_nettype wire

/* File: src/cpu_regfile_stack_pointer.sv */
/*
 * Working register file, X/Y/Z pointers, stack pointer, extended Z byte and
 * the temporary byte used for atomic 16-bit access over the 8-bit data bus.
 * Assumes the execution logic issues at most one data access per cycle and
 * keeps the low-then-high byte order for 16-bit registers.
 * Same-cycle conflicts resolve as pointer update over result write over data
 * write for a working register, and stack operation over data write for the
 * stack pointer; the losing write is dropped without notice.
 * The temporary byte is shared by both stack pointer halves and by direct
 * access at its own data address, which I/O instructions cannot reach.
 */
// Functional notes
// - Working registers 0..31 appear at data addresses 0x00..0x1F.
// - Registers 0x1A..0x1F form X, Y, Z pointers, even register low byte.
// - Pointers support fixed displacement, post-increment and pre-decrement modes.
// - Stack grows downward; stack pointer marks the top of stack.
// - Push decrements stack pointer by one, pop increments by one.
// - Call or interrupt decrements stack pointer by two, returns increment by two.
// - Stack pointer low byte at base offset, high byte at base plus one.
// - Stack pointer resets to 0x10FF; top two bits read zero, read-only.
// - I/O addresses 0x00..0x3F map to data addresses plus 0x20.
// - Extended registers from 0x60 reachable only by data-space accesses.
// - Extended program loads and stores prefix Z with extended byte; plain loads don't.
// - Unimplemented extended byte bits read as zero.
// - Low write goes to temporary; high write copies it into low half.
// - Low read captures high half into temporary; high read returns it.
// - Temporary byte register is directly readable and writable.
// - File supplies two byte operands and accepts byte or 16-bit results.
`default_nettype none
module cpu_regfile_stack_pointer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] rdAddrA,
    input wire logic [4:0] rdAddrB,
    input wire logic resultWrite,
    input wire logic resultWide,
    input wire logic [4:0] resultAddr,
    input wire logic [15:0] resultData,
    input wire regfile_pkg::ptr_sel_type ptrSel,
    input wire regfile_pkg::ptr_mode_type ptrMode,
    input wire logic [5:0] ptrDisp,
    input wire regfile_pkg::stack_op_type stackOp,
    input wire regfile_pkg::prog_op_type progOp,
    input wire logic dataIo,
    input wire logic dataRead,
    input wire logic dataWrite,
    input wire logic [15:0] dataAddr,
    input wire logic [7:0] dataWdata,
    output logic [7:0] operandA,
    output logic [7:0] operandB,
    output logic [15:0] ptrAddress,
    output logic [15:0] stackAddress,
    output logic [23:0] progAddress,
    output logic [7:0] readData,
    output logic readHit,
    output logic [15:0] stackPointer
);
    localparam int GPR_COUNT_W = regfile_pkg::GPR_COUNT;

    typedef struct packed {
        logic [GPR_COUNT_W-1:0][7:0] gpr;
        logic [15:0] sp;
        logic [7:0] extZ;
        logic [7:0] temp;
        logic [7:0] opA;
        logic [7:0] opB;
        logic [15:0] ptrAddr;
        logic [15:0] stkAddr;
        logic [23:0] progAddr;
        logic [7:0] rdData;
        logic rdHit;
    } state_type;

    // where a data access lands once its address is decoded
    typedef enum logic [2:0] {TGT_NONE, TGT_GPR, TGT_EXTZ, TGT_SP_LOW, TGT_SP_HIGH, TGT_TEMP} target_type;

    state_type state;
    state_type next_state;

    logic [4:0] ptrLow;
    logic [15:0] ptrValue;
    logic [7:0] ptrStep;
    logic [15:0] ptrMoved;
    logic [7:0] spStep;
    logic [15:0] spMoved;
    logic [15:0] effAddr;
    target_type target;

    function automatic logic [4:0] lowIndex(input regfile_pkg::ptr_sel_type sel);
        unique case (sel)
            regfile_pkg::PTR_X: lowIndex = regfile_pkg::X_LOW_INDEX;
            regfile_pkg::PTR_Y: lowIndex = regfile_pkg::Y_LOW_INDEX;
            regfile_pkg::PTR_Z: lowIndex = regfile_pkg::Z_LOW_INDEX;
            default: lowIndex = regfile_pkg::Z_LOW_INDEX;
        endcase
    endfunction

    function automatic logic [4:0] evenOf(input logic [4:0] idx);
        evenOf = {idx[4:1], 1'b0};
    endfunction

    function automatic logic [4:0] oddOf(input logic [4:0] idx);
        oddOf = {idx[4:1], 1'b1};
    endfunction

    function automatic logic [15:0] pairValue(input state_type s, input logic [4:0] low);
        pairValue = {s.gpr[oddOf(low)], s.gpr[evenOf(low)]};
    endfunction

    // bits above the implemented range must never take a one
    function automatic logic [15:0] clipSp(input logic [15:0] value);
        clipSp = value & regfile_pkg::SP_IMPL_MASK;
    endfunction

    // I/O accesses arrive here already moved up by the I/O offset
    function automatic target_type decodeTarget(input logic [15:0] addr);
        if (addr <= regfile_pkg::GPR_LAST_ADDR) begin
            decodeTarget = TGT_GPR;
        end else if (addr == regfile_pkg::EXTZ_ADDR) begin
            decodeTarget = TGT_EXTZ;
        end else if (addr == regfile_pkg::SP_LOW_ADDR) begin
            decodeTarget = TGT_SP_LOW;
        end else if (addr == regfile_pkg::SP_LOW_ADDR + regfile_pkg::SP_HIGH_OFFSET) begin
            decodeTarget = TGT_SP_HIGH;
        end else if (addr == regfile_pkg::TEMP_ADDR) begin
            decodeTarget = TGT_TEMP;
        end else begin
            decodeTarget = TGT_NONE;
        end
    endfunction

    always_comb begin
        ptrLow = lowIndex(ptrSel);
        ptrValue = pairValue(state, ptrLow);
        unique case (ptrMode)
            regfile_pkg::PTR_NONE: ptrStep = 8'h00;
            regfile_pkg::PTR_DISP: ptrStep = {2'b00, ptrDisp};
            regfile_pkg::PTR_POSTINC: ptrStep = regfile_pkg::STEP_INC1;
            regfile_pkg::PTR_PREDEC: ptrStep = regfile_pkg::STEP_DEC1;
        endcase
        unique case (stackOp)
            regfile_pkg::STK_PUSH: spStep = regfile_pkg::STEP_DEC1;
            regfile_pkg::STK_POP: spStep = regfile_pkg::STEP_INC1;
            regfile_pkg::STK_CALL: spStep = regfile_pkg::STEP_DEC2;
            regfile_pkg::STK_RET: spStep = regfile_pkg::STEP_INC2;
            default: spStep = 8'h00;
        endcase
        // I/O instructions only carry six address bits, so they never reach 0x60 and up
        if (dataIo) begin
            effAddr = {10'h000, dataAddr[5:0] & regfile_pkg::IO_LAST_ADDR}
                + regfile_pkg::IO_DATA_OFFSET;
        end else begin
            effAddr = dataAddr;
        end
        target = decodeTarget(effAddr);
    end

    sixteen_step ptrAdder (
        .value(ptrValue),
        .step(ptrStep),
        .result(ptrMoved)
    );

    sixteen_step spAdder (
        .value(state.sp),
        .step(spStep),
        .result(spMoved)
    );

    always_comb begin
        next_state = state;
        next_state.rdHit = 1'b0;
        next_state.rdData = 8'h00;
        next_state.opA = state.gpr[rdAddrA];
        next_state.opB = state.gpr[rdAddrB];

        // data-space / I/O access; the temporary byte couples the two halves of SP
        if (dataWrite) begin
            unique case (target)
                TGT_GPR: begin
                    next_state.gpr[effAddr[4:0]] = dataWdata;
                end
                TGT_EXTZ: begin
                    next_state.extZ = dataWdata & regfile_pkg::EXTZ_IMPL_MASK;
                end
                TGT_SP_LOW: begin
                    next_state.temp = dataWdata;
                end
                TGT_SP_HIGH: begin
                    next_state.sp = clipSp({dataWdata, state.temp});
                end
                TGT_TEMP: begin
                    next_state.temp = dataWdata;
                end
                TGT_NONE: begin
                    // unmapped writes are dropped
                    next_state.rdHit = 1'b0;
                end
            endcase
        end else if (dataRead) begin
            next_state.rdHit = 1'b1;
            unique case (target)
                TGT_GPR: begin
                    next_state.rdData = state.gpr[effAddr[4:0]];
                end
                TGT_EXTZ: begin
                    next_state.rdData = state.extZ & regfile_pkg::EXTZ_IMPL_MASK;
                end
                TGT_SP_LOW: begin
                    next_state.rdData = state.sp[7:0];
                    next_state.temp = state.sp[15:8];
                end
                TGT_SP_HIGH: begin
                    next_state.rdData = state.temp;
                end
                TGT_TEMP: begin
                    next_state.rdData = state.temp;
                end
                TGT_NONE: begin
                    // unmapped reads answer nothing
                    next_state.rdHit = 1'b0;
                end
            endcase
        end

        // result write; wide results land on an even/odd pair
        if (resultWrite) begin
            if (resultWide) begin
                next_state.gpr[evenOf(resultAddr)] = resultData[7:0];
                next_state.gpr[oddOf(resultAddr)] = resultData[15:8];
            end else begin
                next_state.gpr[resultAddr] = resultData[7:0];
            end
        end

        // pointer update comes last so it wins over a same-cycle write to the pair
        unique case (ptrMode)
            regfile_pkg::PTR_NONE: begin
                next_state.ptrAddr = state.ptrAddr;
            end
            regfile_pkg::PTR_DISP: begin
                next_state.ptrAddr = ptrMoved;
            end
            regfile_pkg::PTR_POSTINC: begin
                next_state.ptrAddr = ptrValue;
                next_state.gpr[evenOf(ptrLow)] = ptrMoved[7:0];
                next_state.gpr[oddOf(ptrLow)] = ptrMoved[15:8];
            end
            regfile_pkg::PTR_PREDEC: begin
                next_state.ptrAddr = ptrMoved;
                next_state.gpr[evenOf(ptrLow)] = ptrMoved[7:0];
                next_state.gpr[oddOf(ptrLow)] = ptrMoved[15:8];
            end
        endcase

        // push/call store at the current top, pop/return read just above it
        unique case (stackOp)
            regfile_pkg::STK_PUSH, regfile_pkg::STK_CALL: begin
                next_state.stkAddr = state.sp;
                next_state.sp = clipSp(spMoved);
            end
            regfile_pkg::STK_POP, regfile_pkg::STK_RET: begin
                next_state.stkAddr = state.sp + 16'h0001;
                next_state.sp = clipSp(spMoved);
            end
            default: begin
                next_state.stkAddr = state.stkAddr;
            end
        endcase

        unique case (progOp)
            regfile_pkg::PROG_NONE: next_state.progAddr = state.progAddr;
            regfile_pkg::PROG_LOAD: begin
                next_state.progAddr = {8'h00, pairValue(state, regfile_pkg::Z_LOW_INDEX)};
            end
            regfile_pkg::PROG_EXT_LOAD, regfile_pkg::PROG_STORE: begin
                next_state.progAddr = {state.extZ, pairValue(state, regfile_pkg::Z_LOW_INDEX)};
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.sp <= regfile_pkg::SP_RESET;
            state.extZ <= regfile_pkg::EXTZ_RESET;
            state.temp <= regfile_pkg::TEMP_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign operandA = state.opA;
    assign operandB = state.opB;
    assign ptrAddress = state.ptrAddr;
    assign stackAddress = state.stkAddr;
    assign progAddress = state.progAddr;
    assign readData = state.rdData;
    assign readHit = state.rdHit;
    assign stackPointer = state.sp;
endmodule
`default_nettype wire

/* File: testbench/regfile_props.sv */
/*
 * Concurrent checks on the stack pointer, its byte access and program addressing.
 * Assumes it is bound into the register file top and sees only its ports.
 */
`default_nettype none
module regfile_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire regfile_pkg::stack_op_type stackOp,
    input wire regfile_pkg::prog_op_type progOp,
    input wire logic dataIo,
    input wire logic dataRead,
    input wire logic dataWrite,
    input wire logic [15:0] dataAddr,
    input wire logic [7:0] dataWdata,
    input wire logic [7:0] readData,
    input wire logic readHit,
    input wire logic [15:0] stackPointer,
    input wire logic [23:0] progAddress
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic quiet;
    // a same-cycle stack op would win over the byte access
    assign quiet = stackOp == regfile_pkg::STK_NONE && !dataIo;
    sequence lowWr; dataWrite && quiet && dataAddr == 16'h005D; endsequence
    sequence highWr; dataWrite && quiet && dataAddr == 16'h005E; endsequence
    sequence lowRd; dataRead && !dataWrite && quiet && dataAddr == 16'h005D; endsequence
    sequence highRd; dataRead && !dataWrite && quiet && dataAddr == 16'h005E; endsequence
    sp_push_a: assert property (stackOp == regfile_pkg::STK_PUSH |=>
        stackPointer == (($past(stackPointer) - 16'h0001) & 16'h3FFF)) else $error("push step wrong");
    sp_call_a: assert property (stackOp == regfile_pkg::STK_CALL |=>
        stackPointer == (($past(stackPointer) - 16'h0002) & 16'h3FFF)) else $error("call step wrong");
    sp_pop_a: assert property (stackOp == regfile_pkg::STK_POP |=>
        stackPointer == (($past(stackPointer) + 16'h0001) & 16'h3FFF)) else $error("pop step wrong");
    sp_ret_a: assert property (stackOp == regfile_pkg::STK_RET |=>
        stackPointer == (($past(stackPointer) + 16'h0002) & 16'h3FFF)) else $error("return step wrong");
    sp_top_zero_a: assert property (stackPointer[15:14] == 2'h0)
        else $error("stack pointer top bits set");
    low_read_a: assert property (lowRd |=> readHit && readData == $past(stackPointer[7:0]))
        else $error("low byte read wrong");
    high_read_a: assert property (lowRd ##1 highRd |=> readData == $past(stackPointer[15:8], 2))
        else $error("high byte read not captured");
    pair_write_a: assert property (lowWr ##1 highWr |=>
        stackPointer == ({$past(dataWdata), $past(dataWdata, 2)} & 16'h3FFF)) else $error("pair write wrong");
    no_hit_a: assert property (!dataRead |=> !readHit && readData == 8'h00)
        else $error("read answer without read");
    plain_load_a: assert property (progOp == regfile_pkg::PROG_LOAD |=> progAddress[23:16] == 8'h00)
        else $error("plain load used extended byte");
endmodule
bind cpu_regfile_stack_pointer regfile_props props (.clk(clk), .reset_n(reset_n), .stackOp(stackOp),
    .progOp(progOp), .dataIo(dataIo), .dataRead(dataRead), .dataWrite(dataWrite), .dataAddr(dataAddr),
    .dataWdata(dataWdata), .readData(readData), .readHit(readHit), .stackPointer(stackPointer),
    .progAddress(progAddress));
`default_nettype wire

/* File: testbench/exec_model.sv */
/*
 * Execution-side model driving the byte data accesses of the register file.
 * Assumes callers enter just after a rising edge of clk.
 */
`default_nettype none
module exec_model (
    input wire logic clk,
    input wire logic [7:0] readData,
    input wire logic readHit,
    output var logic dataIo,
    output var logic dataRead,
    output var logic dataWrite,
    output var logic [15:0] dataAddr,
    output var logic [7:0] dataWdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        dataIo = 0;
        dataRead = 0;
        dataWrite = 0;
        dataAddr = 16'h0000;
        dataWdata = 8'h00;
    end
    // callers keep low byte before high byte on 16-bit registers
    // the two halves go out on consecutive edges; a stack op in the high-byte cycle still wins over the write
    task automatic access(input logic io, r, w, input logic [15:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic h);
        dataIo = io;
        dataRead = r;
        dataWrite = w;
        dataAddr = a;
        dataWdata = d;
        @(posedge clk);
        #1;
        q = readData;
        h = readHit;
    endtask
    // released lines show junk, not the last value
    task automatic release_bus();
        dataRead = 0;
        dataWrite = 0;
        dataAddr = ~dataAddr;
        dataWdata = ~dataWdata;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench of the register file, pointers and stack pointer.
 * Assumes the execution model instance drives the data access strobes.
 */
`default_nettype none
`define CHK(n, e, s) begin testsRun++; if ((s) !== (e)) begin fails++; \
    $display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0;
    logic reset_n = 0;
    logic resultWrite = 0;
    logic resultWide = 0;
    logic [4:0] rdAddrA = 0, rdAddrB = 0, resultAddr = 0;
    logic [15:0] resultData = 0;
    logic [5:0] ptrDisp = 0;
    regfile_pkg::ptr_sel_type ptrSel = regfile_pkg::PTR_X;
    regfile_pkg::ptr_mode_type ptrMode = regfile_pkg::PTR_NONE;
    regfile_pkg::stack_op_type stackOp = regfile_pkg::STK_NONE;
    regfile_pkg::prog_op_type progOp = regfile_pkg::PROG_NONE;
    wire logic dataIo, dataRead, dataWrite;
    wire logic [15:0] dataAddr;
    wire logic [7:0] dataWdata;
    logic [7:0] operandA, operandB, readData, rd;
    logic [15:0] ptrAddress, stackAddress, stackPointer;
    logic [23:0] progAddress;
    logic readHit, hit;
    int fails = 0, testsRun = 0, sp, v, t, p16, ext;
    int regs [32];
    int dl [4] = '{-1, -2, 1, 2};
    regfile_pkg::stack_op_type opList [4] = '{regfile_pkg::STK_PUSH, regfile_pkg::STK_CALL,
        regfile_pkg::STK_POP, regfile_pkg::STK_RET};
    always #25 clk = ~clk;
    exec_model p (.clk(clk), .readData(readData), .readHit(readHit), .dataIo(dataIo), .dataRead(dataRead),
        .dataWrite(dataWrite), .dataAddr(dataAddr), .dataWdata(dataWdata));
    cpu_regfile_stack_pointer uut (.clk(clk), .reset_n(reset_n), .rdAddrA(rdAddrA), .rdAddrB(rdAddrB),
        .resultWrite(resultWrite), .resultWide(resultWide), .resultAddr(resultAddr), .resultData(resultData),
        .ptrSel(ptrSel), .ptrMode(ptrMode), .ptrDisp(ptrDisp), .stackOp(stackOp), .progOp(progOp),
        .dataIo(dataIo), .dataRead(dataRead), .dataWrite(dataWrite), .dataAddr(dataAddr), .dataWdata(dataWdata),
        .operandA(operandA), .operandB(operandB), .ptrAddress(ptrAddress), .stackAddress(stackAddress),
        .progAddress(progAddress), .readData(readData), .readHit(readHit), .stackPointer(stackPointer));
    task automatic tick(); @(posedge clk); #1; endtask
    task automatic acc(input logic io, r, w, input logic [15:0] a, input logic [7:0] d);
        p.access(io, r, w, a, d, rd, hit);
    endtask
    // a clock edge between release and the next access keeps one assignment per step
    task automatic idle(); p.release_bus(); tick(); endtask
    task automatic wrapUp();
        if (fails == 0 && testsRun > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #250000;
        fails++;
        wrapUp();
    end
    initial begin
        void'($urandom(32'h9E71B720));
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1;
        sp = 16'h10FF;
        `CHK("sp", sp, stackPointer)
        acc(0, 1, 0, 16'h005D, 8'h00); `CHK("spl", sp & 255, rd)
        acc(0, 1, 0, 16'h005E, 8'h00); `CHK("sph", sp >> 8, rd)
        v = $urandom;
        acc(0, 0, 1, 16'h005D, v[7:0]);
        acc(0, 0, 1, 16'h005E, v[15:8] | 8'hC0);
        sp = v & 16'h3FFF;
        `CHK("spw", sp, stackPointer)
        t = $urandom & 63;
        acc(0, 0, 1, 16'h0060, 8'h00);
        acc(0, 0, 1, 16'h005E, 8'(t));
        sp = t << 8;
        `CHK("tmpw", sp, stackPointer)
        acc(0, 1, 0, 16'h005D, 8'h00); `CHK("spl0", 0, rd)
        idle();
        // borrow into the high byte after the capture
        stackOp = regfile_pkg::STK_PUSH;
        tick();
        stackOp = regfile_pkg::STK_NONE;
        sp = (sp - 1) & 16'h3FFF;
        `CHK("borrow", sp, stackPointer)
        acc(0, 1, 0, 16'h005E, 8'h00); `CHK("cap", t, rd)
        acc(0, 1, 0, 16'h0060, 8'h00); `CHK("tmpr", t, rd)
        idle();
        for (int i = 0; i < 8; i++) begin
            stackOp = opList[i % 4];
            tick();
            `CHK("sadr", (dl[i % 4] < 0 ? sp : sp + 1) & 16'h3FFF, stackAddress)
            sp = (sp + dl[i % 4]) & 16'h3FFF;
            `CHK("spop", sp, stackPointer)
        end
        stackOp = regfile_pkg::STK_NONE;
        for (int i = 0; i < 32; i++) begin
            regs[i] = $urandom & 255;
            acc(0, 0, 1, 16'(i), 8'(regs[i]));
        end
        idle();
        for (int i = 0; i < 32; i++) begin
            rdAddrA = 5'(i);
            rdAddrB = 5'(31 - i);
            acc(0, 1, 0, 16'(i), 8'h00); `CHK("rdr", regs[i], rd)
            `CHK("opa", regs[i], operandA)
            `CHK("opb", regs[31 - i], operandB)
        end
        ext = $urandom & 255;
        acc(1, 0, 1, 16'h003B, 8'(ext));
        acc(0, 1, 0, 16'h005B, 8'h00); `CHK("extz", ext, rd)
        acc(1, 1, 0, 16'h001A, 8'h00); `CHK("iohit", 0, hit)
        idle();
        for (int k = 0; k < 3; k++) begin
            p16 = (k == 0) ? 16'h00FF : $urandom & 16'hFFFF;
            resultWrite = 1;
            resultWide = 1;
            resultAddr = 5'(26 + 2 * k);
            resultData = 16'(p16);
            ptrSel = regfile_pkg::ptr_sel_type'(k);
            tick();
            resultWrite = 0;
            t = $urandom & 63;
            ptrDisp = 6'(t);
            ptrMode = regfile_pkg::PTR_DISP;
            tick(); `CHK("disp", (p16 + t) & 16'hFFFF, ptrAddress)
            ptrMode = regfile_pkg::PTR_POSTINC;
            tick(); `CHK("pinc", p16, ptrAddress)
            ptrMode = regfile_pkg::PTR_PREDEC;
            tick(); `CHK("pdec", p16, ptrAddress)
            ptrMode = regfile_pkg::PTR_NONE;
            rdAddrA = 5'(26 + 2 * k);
            rdAddrB = 5'(27 + 2 * k);
            tick();
            `CHK("plo", p16 & 255, operandA)
            `CHK("phi", p16 >> 8, operandB)
        end
        for (int i = 1; i < 4; i++) begin
            progOp = regfile_pkg::prog_op_type'(i);
            tick(); `CHK("prog", ((i == 1 ? 0 : ext) << 16) | p16, progAddress)
        end
        progOp = regfile_pkg::PROG_NONE;
        wrapUp();
    end
endmodule
`default_nettype wire
